/* odp2_cfg.svh */
// Register offsets, field positions, reset values for output four select
`ifndef ODP2_CFG_SVH
`define ODP2_CFG_SVH

// Volatile register addresses of the selection bytes, term one
`define ODP2_ADDR_T1_PRI_WD      8'h1d
`define ODP2_ADDR_T1_SEC_GPI     8'h1e
`define ODP2_ADDR_T1_GPI_OUT     8'h1f
// Volatile register addresses of the selection bytes, term two
`define ODP2_ADDR_T2_PRI_WD      8'h20
`define ODP2_ADDR_T2_SEC_GPI     8'h21
`define ODP2_ADDR_T2_GPI_OUT     8'h22
// Shared byte holding the output eight enables of both terms
`define ODP2_ADDR_OUT8_SEL       8'h23
// Shared byte holding the manual reset enables of all outputs
`define ODP2_ADDR_MR_EN          8'h40

// Nonvolatile copy of a byte sits at this base plus its address
`define ODP2_NV_BASE             16'h8000

// Bit positions inside the shared bytes
`define ODP2_BIT_T1_OUT8         0
`define ODP2_BIT_T2_OUT8         1
`define ODP2_BIT_MR_OUT4         3

// Reset value of every selection byte
`define ODP2_SEL_RESET           8'h00

// Number of conditions that a product term can take in
`define ODP2_NUM_COND            25

`endif

/* odp2_pkg.sv */
// Types shared by the output four dependency logic
package odp2_pkg;

  // Monitored conditions, each bit high when that source is healthy
  typedef struct packed {
    logic       out_eight_ok;   // Output eight deasserted
    logic [5:0] out_other_ok;   // Outputs one, two, three, five, six, seven
    logic [3:0] logic_in_ok;    // Logic inputs four down to one
    logic [5:0] det_sec_ok;     // Secondary thresholds, detector six..one
    logic [1:0] wdog_ok;        // Watchdog two, watchdog one
    logic [5:0] det_pri_ok;     // Primary thresholds, detector six..one
  } odp2_cond_t;

  // Selection bytes of one product term
  typedef struct packed {
    logic       out8_sel;       // Output eight enable
    logic [7:0] gpi_out_sel;    // Logic inputs three, four and outputs
    logic [7:0] sec_gpi_sel;    // Secondary thresholds, logic inputs one, two
    logic [7:0] pri_wd_sel;     // Primary thresholds and watchdogs
  } odp2_sel_t;

endpackage

/* odp2_out4_dep.sv */
// Product term selection and assert logic for sequencer output four
`timescale 1ns/1ps
`default_nettype none
`include "odp2_cfg.svh"

// Summary of operation
// - 0x20 bits 0-5 enable primary detectors
// - 0x20 bits 6,7 enable watchdogs one, two
// - 0x21 bits 0-5 enable secondary detectors
// - Logic inputs: 0x21 bits 6,7, 0x22 bits 0,1
// - 0x22 bits 2-7 enable other outputs
// - 0x23 bit 1 enables output eight
// - 0x40 bit 3: low manual reset asserts
// - Output deasserts when either term true, unless the 0x40 bit 3 override is active
// - Nonvolatile copy at 0x8000 plus address
// - Term one uses 0x1D-0x1F, 0x23 bit 0
module odp2_out4_dep
  import odp2_pkg::*;
#(
  parameter int SYNC_STAGES = 2          // Flip-flops on each pin input
)(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // Register port at the documented byte addresses
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  // Nonvolatile copy load port
  input  wire logic       nv_wr_en,
  input  wire logic [15:0] nv_addr,
  input  wire logic [7:0] nv_wdata,
  // Monitored conditions, asynchronous to clk_sys
  input  wire logic [5:0] det_pri_ok,
  input  wire logic [5:0] det_sec_ok,
  input  wire logic [1:0] wdog_ok,
  input  wire logic [3:0] logic_in_ok,
  input  wire logic [5:0] out_other_asserted,
  input  wire logic       out_eight_asserted,
  input  wire logic       manual_reset_n,
  // Results
  output logic            seq_output_four_asserted,
  output logic            term_one_true,
  output logic            term_two_true
);

  // Pin bundle: every condition bit plus the manual reset pin on top.
  // Taking the width from the struct keeps pack and unpack in step.
  localparam int NSYNC = $bits(odp2_cond_t) + 1;

  // Reset values of the pin synchronisers: manual reset idles high
  localparam logic [NSYNC-1:0] SYNC_RST = {1'b1, {(NSYNC-1){1'b0}}};

  // Selection bytes
  logic [7:0] t1_pri_wd_r;               // Term one, primary and watchdogs
  logic [7:0] t1_sec_gpi_r;              // Term one, secondary and inputs
  logic [7:0] t1_gpi_out_r;              // Term one, inputs and outputs
  logic [7:0] t2_pri_wd_r;               // Term two, primary and watchdogs
  logic [7:0] t2_sec_gpi_r;              // Term two, secondary and inputs
  logic [7:0] t2_gpi_out_r;              // Term two, inputs and outputs
  logic [7:0] out8_sel_r;                // Shared output eight enables
  logic [7:0] mr_en_r;                   // Shared manual reset enables

  // Unified write strobe from either port
  logic       wr_any;                    // A byte is written this cycle
  logic [7:0] wr_addr;                   // Register address of the write
  logic [7:0] wr_data;                   // Data of the write
  logic       nv_hit;                    // Load port hits the copy window

  // Synchroniser chain
  logic [NSYNC-1:0] sync_r [SYNC_STAGES]; // Stage zero feeds stage one only
  logic [NSYNC-1:0] pins_raw;            // Bundle of raw pin levels
  logic [NSYNC-1:0] pins_s;              // Bundle after the last stage

  // Conditions and enables as vectors
  odp2_cond_t cond;                      // Synchronised healthy flags
  odp2_sel_t  sel_t1;                    // Term one enables
  odp2_sel_t  sel_t2;                    // Term two enables
  logic [`ODP2_NUM_COND-1:0] cond_v;     // Flat healthy vector
  logic [`ODP2_NUM_COND-1:0] en_t1;      // Flat term one enables
  logic [`ODP2_NUM_COND-1:0] en_t2;      // Flat term two enables
  logic [`ODP2_NUM_COND-1:0] pass_t1;    // Per condition pass, term one
  logic [`ODP2_NUM_COND-1:0] pass_t2;    // Per condition pass, term two
  logic       mr_low_s;                  // Manual reset held low
  logic       force_assert;              // Manual reset forces assertion
  logic       assert_nxt;                // Next value of the output

  // Pin bundle, manual reset on top
  assign pins_raw = {manual_reset_n,
                     out_eight_asserted,
                     out_other_asserted,
                     logic_in_ok,
                     det_sec_ok,
                     wdog_ok,
                     det_pri_ok};

  // Two flip-flop synchroniser on every pin input
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < SYNC_STAGES; i++)
        sync_r[i] <= SYNC_RST;
    end
    else
    begin
      sync_r[0] <= pins_raw;
      for (int i = 1; i < SYNC_STAGES; i++)
        sync_r[i] <= sync_r[i-1];
    end
  end

  assign pins_s = sync_r[SYNC_STAGES-1];

  // Unpack the synchronised bundle; outputs count healthy when idle
  always_comb
  begin
    cond.det_pri_ok   = pins_s[5:0];
    cond.wdog_ok      = pins_s[7:6];
    cond.det_sec_ok   = pins_s[13:8];
    cond.logic_in_ok  = pins_s[17:14];
    cond.out_other_ok = ~pins_s[23:18];
    cond.out_eight_ok = ~pins_s[24];
    // Manual reset is the top bit, just above output eight
    mr_low_s          = ~pins_s[NSYNC-1];
  end

  // Nonvolatile address decodes to a byte of this block
  // Copy address window
  // Upper byte picks the window, lower byte names the register
  assign nv_hit  = nv_wr_en &&
                   (nv_addr[15:8] == 8'(`ODP2_NV_BASE >> 8));

  // The register port wins when both ports write in one cycle,
  // since a live write is newer than a stored image
  assign wr_any  = reg_wr_en || nv_hit;
  assign wr_addr = reg_wr_en ? reg_addr : nv_addr[7:0];
  assign wr_data = reg_wr_en ? reg_wdata : nv_wdata;
  // Limitation: a register write to an unmapped byte still drops a load

  // Term one bytes
  // Term one selection storage
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t1_pri_wd_r  <= `ODP2_SEL_RESET;
      t1_sec_gpi_r <= `ODP2_SEL_RESET;
      t1_gpi_out_r <= `ODP2_SEL_RESET;
    end
    else if (wr_any)
    begin
      case (wr_addr)
        `ODP2_ADDR_T1_PRI_WD:  t1_pri_wd_r  <= wr_data;
        `ODP2_ADDR_T1_SEC_GPI: t1_sec_gpi_r <= wr_data;
        `ODP2_ADDR_T1_GPI_OUT: t1_gpi_out_r <= wr_data;
        default: ;                       // Other bytes handled elsewhere
      endcase
    end
  end

  // Term two bytes
  // Term two selection storage
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      t2_pri_wd_r  <= `ODP2_SEL_RESET;
      t2_sec_gpi_r <= `ODP2_SEL_RESET;
      t2_gpi_out_r <= `ODP2_SEL_RESET;
    end
    else if (wr_any)
    begin
      case (wr_addr)
        `ODP2_ADDR_T2_PRI_WD:  t2_pri_wd_r  <= wr_data;
        `ODP2_ADDR_T2_SEC_GPI: t2_sec_gpi_r <= wr_data;
        `ODP2_ADDR_T2_GPI_OUT: t2_gpi_out_r <= wr_data;
        default: ;                       // Other bytes handled elsewhere
      endcase
    end
  end

  // Shared bytes; whole byte kept so other outputs' bits read back
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      out8_sel_r <= `ODP2_SEL_RESET;
      mr_en_r    <= `ODP2_SEL_RESET;
    end
    else if (wr_any)
    begin
      case (wr_addr)
        `ODP2_ADDR_OUT8_SEL: out8_sel_r <= wr_data;
        `ODP2_ADDR_MR_EN:    mr_en_r    <= wr_data;
        default: ;                       // Not a shared byte
      endcase
    end
  end

  // Read back, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata    <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en)
      begin
        case (reg_addr)
          `ODP2_ADDR_T1_PRI_WD:  reg_rdata <= t1_pri_wd_r;
          `ODP2_ADDR_T1_SEC_GPI: reg_rdata <= t1_sec_gpi_r;
          `ODP2_ADDR_T1_GPI_OUT: reg_rdata <= t1_gpi_out_r;
          `ODP2_ADDR_T2_PRI_WD:  reg_rdata <= t2_pri_wd_r;
          `ODP2_ADDR_T2_SEC_GPI: reg_rdata <= t2_sec_gpi_r;
          `ODP2_ADDR_T2_GPI_OUT: reg_rdata <= t2_gpi_out_r;
          `ODP2_ADDR_OUT8_SEL:   reg_rdata <= out8_sel_r;
          `ODP2_ADDR_MR_EN:      reg_rdata <= mr_en_r;
          default:               reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Gather the enables; byte order matches the condition order
  // Term one enable gather
  always_comb
  begin
    sel_t1.pri_wd_sel  = t1_pri_wd_r;
    sel_t1.sec_gpi_sel = t1_sec_gpi_r;
    sel_t1.gpi_out_sel = t1_gpi_out_r;
    sel_t1.out8_sel    = out8_sel_r[`ODP2_BIT_T1_OUT8];
  end

  // Primary detectors and watchdogs in 0x20
  // Output eight enable from bit 1
  always_comb
  begin
    sel_t2.pri_wd_sel  = t2_pri_wd_r;
    sel_t2.sec_gpi_sel = t2_sec_gpi_r;
    sel_t2.gpi_out_sel = t2_gpi_out_r;
    sel_t2.out8_sel    = out8_sel_r[`ODP2_BIT_T2_OUT8];
  end

  // Flat vectors: bit n of the enables pairs with bit n of cond
  // Watchdogs sit at bits 6, 7
  assign cond_v = cond;
  assign en_t1  = sel_t1;
  assign en_t2  = sel_t2;

  // Per condition pass: cleared enable passes regardless of source
  generate
    for (genvar g = 0; g < `ODP2_NUM_COND; g++)
    begin : g_pass
      assign pass_t1[g] = cond_v[g] | ~en_t1[g];
      assign pass_t2[g] = cond_v[g] | ~en_t2[g];
    end
  endgenerate

  // Manual reset override; only bit 3 of the shared byte matters here
  // Manual reset forces assertion
  assign force_assert = mr_en_r[`ODP2_BIT_MR_OUT4] && mr_low_s;

  // Output decision. With no enables set a term is true, so the
  // output deasserts; software must enable something in both terms to hold it.
  // Deassert on either term
  // The override is ORed last so no true term can cancel a held button
  assign assert_nxt = force_assert ||
                      !((&pass_t1) || (&pass_t2));

  // Registered results
  // AND over enabled conditions
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      term_one_true            <= 1'b0;
      term_two_true            <= 1'b0;
      seq_output_four_asserted <= 1'b1;  // Safe: held in reset state
    end
    else
    begin
      // Terms registered beside the output so all three agree in time
      term_one_true            <= &pass_t1;
      term_two_true            <= &pass_t2;
      seq_output_four_asserted <= assert_nxt;
    end
  end

endmodule
`default_nettype wire

/* odp2_monitor.sv */
// Port checker for the output four dependency logic
`timescale 1ns/1ps
`default_nettype none
module odp2_monitor
  import odp2_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rd_valid,
  input wire logic        nv_wr_en,
  input wire logic [15:0] nv_addr,
  input wire logic [7:0]  nv_wdata,
  input wire logic        manual_reset_n,
  input wire logic        seq_output_four_asserted,
  input wire logic        term_one_true,
  input wire logic        term_two_true
);
  logic [7:0] sh_r [8'h1d:8'h40];  // Shadow of the selection bytes
  logic [7:0] rexp;                // Byte a read should return
  logic       t1z;                 // Term one has no enable set
  logic       t2z;                 // Term two has no enable set
  logic       mr_en;               // Manual reset may force output four

  function automatic logic hit(logic [7:0] a);
    return (a >= 8'h1d && a <= 8'h23) || a == 8'h40;
  endfunction

  // Register write wins over an image load in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      for (int i = 8'h1d; i <= 8'h40; i++)
        sh_r[i] <= 8'h00;
    else if (reg_wr_en && hit(reg_addr))
      sh_r[reg_addr] <= reg_wdata;
    else if (!reg_wr_en && nv_wr_en && nv_addr[15:8] == 8'h80 &&
             hit(nv_addr[7:0]))
      sh_r[nv_addr[7:0]] <= nv_wdata;

  // Unmapped places read as zero
  always_comb rexp = hit(reg_addr) ? sh_r[reg_addr] : 8'h00;
  assign t1z = {sh_r[8'h1d], sh_r[8'h1e], sh_r[8'h1f]} == 24'h0
               && !sh_r[8'h23][0];
  assign t2z = {sh_r[8'h20], sh_r[8'h21], sh_r[8'h22]} == 24'h0
               && !sh_r[8'h23][1];
  assign mr_en = sh_r[8'h40][3];

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Pin low meets an enabled override two edges later
  sequence s_mr_seen;
    !manual_reset_n ##2 mr_en;
  endsequence

  property p_rdv; reg_rd_en |=> reg_rd_valid; endproperty
  property p_rdata; reg_rd_en |=> reg_rdata == $past(rexp); endproperty
  property p_hold; !reg_rd_en |=> $stable(reg_rdata); endproperty
  property p_mr; s_mr_seen |=> seq_output_four_asserted; endproperty
  property p_dz;
    !seq_output_four_asserted |-> term_one_true || term_two_true;
  endproperty
  property p_tz;
    (term_one_true || term_two_true) && !$past(mr_en)
      |-> !seq_output_four_asserted;
  endproperty
  property p_t1e; t1z |=> term_one_true; endproperty
  property p_t2e; t2z |=> term_two_true; endproperty

  a_rdv: assert property (p_rdv)
    else $error("read valid missing");
  a_rdata: assert property (p_rdata)
    else $error("read data differs from stored byte");
  a_hold: assert property (p_hold)
    else $error("read data moved without a read");
  a_mr: assert property (p_mr)
    else $error("manual reset did not assert output");
  a_dz: assert property (p_dz)
    else $error("output deasserted with no true term");
  a_tz: assert property (p_tz)
    else $error("output asserted with a true term");
  a_t1e: assert property (p_t1e)
    else $error("empty term one not true");
  a_t2e: assert property (p_t2e)
    else $error("empty term two not true");
endmodule

bind odp2_out4_dep odp2_monitor u_mon (.clk_sys, .arst_n, .reg_wr_en,
  .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
  .nv_wr_en, .nv_addr, .nv_wdata, .manual_reset_n,
  .seq_output_four_asserted, .term_one_true, .term_two_true);
`default_nettype wire

/* odp2_env_model.sv */
// Supplies, watchdogs, neighbour outputs and button around output four
`timescale 1ns/1ps
`default_nettype none
module odp2_env_model
  import odp2_pkg::*;
(
  input  wire logic [24:0] fault,            // High bit = condition faulty
  input  wire logic        mr_press,         // Button held down
  output logic      [5:0]  det_pri_ok,
  output logic      [5:0]  det_sec_ok,
  output logic      [1:0]  wdog_ok,
  output logic      [3:0]  logic_in_ok,
  output logic      [5:0]  out_other_asserted,
  output logic             out_eight_asserted,
  output logic             manual_reset_n
);
  odp2_cond_t cond;  // Healthy view, same order as the select bits

  assign cond               = odp2_cond_t'(~fault);
  assign det_pri_ok         = cond.det_pri_ok;
  assign det_sec_ok         = cond.det_sec_ok;
  assign wdog_ok            = cond.wdog_ok;
  assign logic_in_ok        = cond.logic_in_ok;
  // A faulty neighbour output is one that is asserted
  assign out_other_asserted = ~cond.out_other_ok;
  assign out_eight_asserted = ~cond.out_eight_ok;
  assign manual_reset_n     = !mr_press;
endmodule
`default_nettype wire

/* test_output_dependency_product_two.sv */
// Self-checking bench for output four product term two
`timescale 1ns/1ps
`default_nettype none
module test_output_dependency_product_two;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic        nv_en   = 1'b0;
  logic        mr_press = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [7:0]  wdata   = 8'h00;
  logic [7:0]  nv_data = 8'h00;
  logic [15:0] nv_addr = 16'h0000;
  logic [24:0] fault   = 25'h0;   // Conditions the far side breaks
  logic [24:0] sel;                // One-hot term two enable
  logic [7:0]  rdata;
  logic        rd_valid, out4, t1, t2, out8, mr_n;
  logic [5:0]  pri, sec, other;
  logic [1:0]  wd;
  logic [3:0]  gpi;
  int          err_count = 0;
  int          n_compared = 0;

  always #10 clk_sys = ~clk_sys;

  odp2_env_model u_env (.fault(fault), .mr_press(mr_press),
    .det_pri_ok(pri), .det_sec_ok(sec), .wdog_ok(wd), .logic_in_ok(gpi),
    .out_other_asserted(other), .out_eight_asserted(out8),
    .manual_reset_n(mr_n));

  odp2_out4_dep u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
    .nv_wr_en(nv_en), .nv_addr(nv_addr), .nv_wdata(nv_data),
    .det_pri_ok(pri), .det_sec_ok(sec), .wdog_ok(wd),
    .logic_in_ok(gpi), .out_other_asserted(other),
    .out_eight_asserted(out8), .manual_reset_n(mr_n),
    .seq_output_four_asserted(out4), .term_one_true(t1),
    .term_two_true(t2));

  task automatic check(logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask

  // Answer stands for the one cycle after the taking edge, so it is
  // looked at on the falling edge inside that cycle
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clk_sys);
    rd_en = 1'b1;
    addr  = a;
    @(negedge clk_sys);
    check({7'h0, rd_valid}, 8'h01);
    check(rdata, exp);
    rd_en = 1'b0;
  endtask

  // Two sync stages plus the output register, with margin
  task automatic settle;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    stop_test;
  end

  initial
  begin
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    rd(8'h20, 8'h00);
    // Term one needs every condition healthy
    wr(8'h1d, 8'hff);
    wr(8'h1e, 8'hff);
    wr(8'h1f, 8'hff);
    // Each term two enable alone, in condition order
    for (int i = 0; i < 25; i++)
    begin
      sel = 25'h1 << i;
      wr(8'h20, sel[7:0]);
      wr(8'h21, sel[15:8]);
      wr(8'h22, sel[23:16]);
      wr(8'h23, {6'h0, sel[24], 1'b1});
      fault = sel;
      settle;
      check({5'h0, t1, t2, out4}, 8'h01);
      fault = {sel[23:0], sel[24]};
      settle;
      check({5'h0, t1, t2, out4}, 8'h02);
      fault = 25'h0;
      settle;
      check({5'h0, t1, t2, out4}, 8'h06);
    end
    rd(8'h23, 8'h03);
    rd(8'h1f, 8'hff);
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00);
    // Reduced variant: absent detectors and outputs left disabled, so
    // their faults cannot clear term two; a present one still does
    wr(8'h20, 8'hcf);
    wr(8'h21, 8'hcf);
    wr(8'h22, 8'hf3);
    wr(8'h23, 8'h01);
    fault = 25'h10c3030;
    settle;
    check({5'h0, t1, t2, out4}, 8'h02);
    fault = 25'h10c3031;
    settle;
    check({5'h0, t1, t2, out4}, 8'h01);
    fault = 25'h0;
    // Image load, then a foreign address back to back
    @(negedge clk_sys);
    nv_en   = 1'b1;
    nv_addr = 16'h8040;
    nv_data = 8'h08;
    @(negedge clk_sys);
    nv_addr = 16'h9040;
    nv_data = 8'h00;
    @(negedge clk_sys);
    nv_en = 1'b0;
    rd(8'h40, 8'h08);
    mr_press = 1'b1;
    settle;
    check({7'h0, out4}, 8'h01);
    wr(8'h40, 8'h00);
    settle;
    check({7'h0, out4}, 8'h00);
    mr_press = 1'b0;
    // Second reset in mid-run clears the bytes
    arst_n = 1'b0;
    settle;
    check({5'h0, t1, t2, out4}, 8'h01);
    arst_n = 1'b1;
    rd(8'h22, 8'h00);
    // Empty terms after reset are true, so the output drops
    settle;
    check({5'h0, t1, t2, out4}, 8'h06);
    stop_test;
  end
endmodule
`default_nettype wire
